/* rtl/phy_status_regs.svh */
/*
 * Register indices, field positions and reset values of the status
 * summary block. Byte address on the register bus is index times four.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef PHY_STATUS_REGS_SVH
`define PHY_STATUS_REGS_SVH

// Register indices; byte address is the index shifted left by two.
`define IDX_BASIC_STATUS     8'h01
`define IDX_AUTONEG_EXPAN    8'h06
`define IDX_SUMMARY          8'h10
`define IDX_FALSE_CARRIER    8'h14
`define IDX_RX_ERROR         8'h15
`define IDX_PCS_CONFIG       8'h16
`define IDX_PHY_CONTROL      8'h19
`define IDX_TENBASE_STATUS   8'h1a
`define IDX_IRQ_STATUS       8'h1c
`define IDX_IRQ_MASK         8'h1d

// Field positions.
`define POS_SD_QUALIFY       8
`define POS_XOVER_AUTO       15
`define POS_XOVER_FORCE      14

// Reset values.
`define RST_SD_QUALIFY       1'b1
`define RST_XOVER_AUTO       1'b1
`define RST_XOVER_FORCE      1'b0
`define RST_IRQ_MASK         7'h00

`endif

/* rtl/phy_status_pkg.sv */
/*
 * Types shared by the status summary block and its bench.
 * Assumes nothing of its surroundings.
 */
package phy_status_pkg;

    // One-cycle event pulses from the detectors.
    typedef struct packed {
        logic rx_error;
        logic false_carrier;
        logic polarity_inverted;
        logic page_received;
        logic remote_fault;
    } phy_events_t;

    // Live levels from the receive path and crossover logic.
    typedef struct packed {
        logic raw_signal_detect;
        logic descrambler_lock;
        logic crossover_algo_swapped;
    } phy_levels_t;

endpackage

/* rtl/phy_status_summary_upper.sv */
/*
 * Upper half of the status summary register with an APB slave.
 * Assumes synchronous inputs on pclk, events as one-cycle pulses.
 */
// Behaviour
// - Bits 15 and 7 read zero, writes ignored
// - Bit 14 high when pairs crossed
// - Crossover bit follows enable, force, algorithm
// - Receive error latches high until counter read
// - Polarity bit cleared by tenbase register read
// - False carrier latches high until counter read
// - Signal detect optionally qualified by descrambler lock
// - Signal detect latches low until read
// - Descrambler lock latches low until read
// - Page received cleared by expansion register read
// - Remote fault cleared by basic status read
// - Summary register decoded at index 10h
`timescale 1ns/100ps
`include "phy_status_regs.svh"

module phy_status_summary_upper (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [9:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire phy_status_pkg::phy_events_t events,
    input  wire phy_status_pkg::phy_levels_t levels,
    input  wire logic [5:0]                 lower_status,
    output logic                            crossover_pairs,
    output logic                            irq
);

    // Decode a word-aligned register index.
    function automatic logic hit(input logic [9:0] a, input logic [7:0] i);
        return (a[9:2] == i) && (a[1:0] == 2'h0);
    endfunction

    logic [31:0] prdata_ff, nxt_prdata;
    logic        pready_ff, nxt_pready;
    logic        pslverr_ff, nxt_pslverr;
    logic        crossover_ff, nxt_crossover;
    logic        rxerr_ff, nxt_rxerr;
    logic        pol_ff, nxt_pol;
    logic        fcs_ff, nxt_fcs;
    logic        sd_ll_ff, nxt_sd_ll;
    logic        lock_ll_ff, nxt_lock_ll;
    logic        page_ff, nxt_page;
    logic        rf_ff, nxt_rf;
    logic        sd_qual_ff, nxt_sd_qual;
    logic        xauto_ff, nxt_xauto;
    logic        xforce_ff, nxt_xforce;
    logic [6:0]  irq_stat_ff, nxt_irq_stat;
    logic [6:0]  irq_mask_ff, nxt_irq_mask;
    logic        irq_ff, nxt_irq;
    logic        capture, done, rd_cap, wr_done;
    logic        sd_now, mapped;
    logic [15:0] summary;
    logic [6:0]  irq_evt;

    // The answer is computed one cycle into the access phase and the
    // read side effects happen at that same edge, so the data returned
    // and the clearing always agree.
    assign capture = psel & penable & ~pready_ff;
    assign done    = psel & penable & pready_ff;
    assign rd_cap  = capture & ~pwrite;
    assign wr_done = done & pwrite;

    // Qualified signal detect as fed to the link monitor.
    assign sd_now = levels.raw_signal_detect &
                    (~sd_qual_ff | levels.descrambler_lock);

    // Summary word; reserved bits are hard zero.
    assign summary = {1'b0, crossover_ff, rxerr_ff, pol_ff, fcs_ff,
                      sd_ll_ff, lock_ll_ff, page_ff, 1'b0, rf_ff,
                      lower_status};

    assign mapped = hit(paddr, `IDX_SUMMARY) ||
                    hit(paddr, `IDX_BASIC_STATUS) ||
                    hit(paddr, `IDX_AUTONEG_EXPAN) ||
                    hit(paddr, `IDX_FALSE_CARRIER) ||
                    hit(paddr, `IDX_RX_ERROR) ||
                    hit(paddr, `IDX_PCS_CONFIG) ||
                    hit(paddr, `IDX_PHY_CONTROL) ||
                    hit(paddr, `IDX_TENBASE_STATUS) ||
                    hit(paddr, `IDX_IRQ_STATUS) ||
                    hit(paddr, `IDX_IRQ_MASK);

    // Bus answer: one wait state, error on an unmapped word.
    always_comb begin
        nxt_pready  = capture;
        nxt_pslverr = capture & ~mapped;
        nxt_prdata  = prdata_ff;
        if (rd_cap) begin
            nxt_prdata = 32'h0000_0000;
            if (hit(paddr, `IDX_SUMMARY)) begin
                nxt_prdata[15:0] = summary;
            end else if (hit(paddr, `IDX_PCS_CONFIG)) begin
                nxt_prdata[`POS_SD_QUALIFY] = sd_qual_ff;
            end else if (hit(paddr, `IDX_PHY_CONTROL)) begin
                nxt_prdata[`POS_XOVER_AUTO]  = xauto_ff;
                nxt_prdata[`POS_XOVER_FORCE] = xforce_ff;
            end else if (hit(paddr, `IDX_IRQ_STATUS)) begin
                nxt_prdata[6:0] = irq_stat_ff;
            end else if (hit(paddr, `IDX_IRQ_MASK)) begin
                nxt_prdata[6:0] = irq_mask_ff;
            end
        end
    end

    // Status flags. A new event beats a clear in the same cycle, so no
    // event is ever lost to a badly timed read.
    always_comb begin
        // Force wins over the algorithm; disabled auto means straight.
        if (xforce_ff) begin
            nxt_crossover = 1'b1;
        end else if (xauto_ff) begin
            nxt_crossover = levels.crossover_algo_swapped;
        end else begin
            nxt_crossover = 1'b0;
        end
        nxt_rxerr = events.rx_error |
                    (rxerr_ff & ~(rd_cap & hit(paddr, `IDX_RX_ERROR)));
        nxt_fcs   = events.false_carrier |
                    (fcs_ff &
                     ~(rd_cap & hit(paddr, `IDX_FALSE_CARRIER)));
        nxt_pol   = events.polarity_inverted |
                    (pol_ff &
                     ~(rd_cap & hit(paddr, `IDX_TENBASE_STATUS)));
        nxt_page  = events.page_received |
                    (page_ff &
                     ~(rd_cap & hit(paddr, `IDX_AUTONEG_EXPAN)));
        nxt_rf    = events.remote_fault |
                    (rf_ff & ~(rd_cap & hit(paddr, `IDX_BASIC_STATUS)));
        // Latch-low: a drop holds zero until the summary is read.
        if (rd_cap && hit(paddr, `IDX_SUMMARY)) begin
            nxt_sd_ll   = sd_now;
            nxt_lock_ll = levels.descrambler_lock;
        end else begin
            nxt_sd_ll   = sd_ll_ff & sd_now;
            nxt_lock_ll = lock_ll_ff & levels.descrambler_lock;
        end
    end

    // Software controls and interrupt registers.
    always_comb begin
        irq_evt = {lock_ll_ff & ~levels.descrambler_lock,
                   sd_ll_ff & ~sd_now,
                   events.remote_fault, events.page_received,
                   events.polarity_inverted, events.false_carrier,
                   events.rx_error};
        nxt_sd_qual  = sd_qual_ff;
        nxt_xauto    = xauto_ff;
        nxt_xforce   = xforce_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_stat = irq_stat_ff;
        if (wr_done && hit(paddr, `IDX_PCS_CONFIG)) begin
            nxt_sd_qual = pwdata[`POS_SD_QUALIFY];
        end
        if (wr_done && hit(paddr, `IDX_PHY_CONTROL)) begin
            nxt_xauto  = pwdata[`POS_XOVER_AUTO];
            nxt_xforce = pwdata[`POS_XOVER_FORCE];
        end
        if (wr_done && hit(paddr, `IDX_IRQ_MASK)) begin
            nxt_irq_mask = pwdata[6:0];
        end
        if (wr_done && hit(paddr, `IDX_IRQ_STATUS)) begin
            nxt_irq_stat = irq_stat_ff & ~pwdata[6:0];
        end
        nxt_irq_stat = nxt_irq_stat | irq_evt;
        nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
    end

    // Every bit comes out of reset at its constant value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff    <= 32'h0000_0000;
            pready_ff    <= 1'b0;
            pslverr_ff   <= 1'b0;
            crossover_ff <= 1'b0;
            rxerr_ff     <= 1'b0;
            pol_ff       <= 1'b0;
            fcs_ff       <= 1'b0;
            sd_ll_ff     <= 1'b0;
            lock_ll_ff   <= 1'b0;
            page_ff      <= 1'b0;
            rf_ff        <= 1'b0;
            sd_qual_ff   <= `RST_SD_QUALIFY;
            xauto_ff     <= `RST_XOVER_AUTO;
            xforce_ff    <= `RST_XOVER_FORCE;
            irq_mask_ff  <= `RST_IRQ_MASK;
            irq_stat_ff  <= 7'h00;
            irq_ff       <= 1'b0;
        end else begin
            prdata_ff    <= nxt_prdata;
            pready_ff    <= nxt_pready;
            pslverr_ff   <= nxt_pslverr;
            crossover_ff <= nxt_crossover;
            rxerr_ff     <= nxt_rxerr;
            pol_ff       <= nxt_pol;
            fcs_ff       <= nxt_fcs;
            sd_ll_ff     <= nxt_sd_ll;
            lock_ll_ff   <= nxt_lock_ll;
            page_ff      <= nxt_page;
            rf_ff        <= nxt_rf;
            sd_qual_ff   <= nxt_sd_qual;
            xauto_ff     <= nxt_xauto;
            xforce_ff    <= nxt_xforce;
            irq_mask_ff  <= nxt_irq_mask;
            irq_stat_ff  <= nxt_irq_stat;
            irq_ff       <= nxt_irq;
        end
    end

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign crossover_pairs = crossover_ff;
    assign irq             = irq_ff;

    // Checks on the summary bits, all on pclk.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reserved_zero: assert property (
        pready_ff && !pslverr_ff && $past(rd_cap) &&
        $past(hit(paddr, `IDX_SUMMARY)) |->
        prdata_ff[15] == 1'b0 && prdata_ff[7] == 1'b0)
        else $error("Reserved summary bit read as one.");

    a_xover_force: assert property (
        xforce_ff |=> crossover_ff)
        else $error("Forced crossover not reported.");

    a_xover_follow: assert property (
        xauto_ff && !xforce_ff |=>
        crossover_ff == $past(levels.crossover_algo_swapped))
        else $error("Crossover bit did not follow algorithm.");

    a_rxerr_hold: assert property (
        rxerr_ff && !(rd_cap && hit(paddr, `IDX_RX_ERROR)) |=> rxerr_ff)
        else $error("Receive error latch dropped without read.");

    a_fcs_set: assert property (
        events.false_carrier |=> fcs_ff)
        else $error("False carrier event not latched.");

    a_sd_latch_low: assert property (
        !sd_ll_ff && !(rd_cap && hit(paddr, `IDX_SUMMARY)) |=> !sd_ll_ff)
        else $error("Signal detect rose without a read.");

    a_lock_drop: assert property (
        !levels.descrambler_lock |=> !lock_ll_ff)
        else $error("Lock loss not latched low.");

    a_page_keep: assert property (
        page_ff && rd_cap && hit(paddr, `IDX_SUMMARY) |=> page_ff)
        else $error("Summary read cleared page received.");

    a_rf_clear: assert property (
        rd_cap && hit(paddr, `IDX_BASIC_STATUS) &&
        !events.remote_fault |=> !rf_ff)
        else $error("Basic status read did not clear fault.");

    a_pol_keep: assert property (
        pol_ff && !(rd_cap && hit(paddr, `IDX_TENBASE_STATUS)) |=> pol_ff)
        else $error("Polarity bit cleared without its read.");

    // Every latch-high flag must take its event, even during a clear.
    a_rxerr_set: assert property (
        events.rx_error |=> rxerr_ff)
        else $error("Receive error event not latched.");

    a_pol_set: assert property (
        events.polarity_inverted |=> pol_ff)
        else $error("Polarity event not latched.");

    a_page_set: assert property (
        events.page_received |=> page_ff)
        else $error("Page received event not latched.");

    a_rf_set: assert property (
        events.remote_fault |=> rf_ff)
        else $error("Remote fault event not latched.");

    // With qualification on, a lock loss must pull detect low too.
    a_sd_qualify: assert property (
        sd_qual_ff && !levels.descrambler_lock |=> !sd_ll_ff)
        else $error("Qualified detect ignored lock loss.");

    // A summary read must not disturb the false carrier latch.
    a_fcs_hold: assert property (
        fcs_ff && !(rd_cap && hit(paddr, `IDX_FALSE_CARRIER)) |=> fcs_ff)
        else $error("False carrier latch dropped without read.");

    // The summary word answers after one wait state and without error.
    a_summary_ok: assert property (
        capture && hit(paddr, `IDX_SUMMARY) |=> pready_ff && !pslverr_ff)
        else $error("Summary access not answered cleanly.");

endmodule // phy_status_summary_upper

/* testbench/phy_status_summary_upper_tb.sv */
/*
 * Self-checking bench for the upper status summary block over APB.
 * Assumes the design package and register header are compiled first.
 */
`timescale 1ns/100ps
`include "phy_status_regs.svh"

module phy_status_summary_upper_tb;
    logic                        pclk, presetn, psel, penable, pwrite;
    logic [9:0]                  paddr;
    logic [31:0]                 pwdata, prdata, rd_data;
    logic                        pready, pslverr, crossover_pairs, irq;
    logic                        rd_err;
    phy_status_pkg::phy_events_t events;
    phy_status_pkg::phy_levels_t levels;
    logic [5:0]                  lower_status;
    int                          fails, n_checks, cyc;
    localparam logic [31:0]      LOW = 32'h0000_002a;

    phy_status_summary_upper dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .events(events),
        .levels(levels), .lower_status(lower_status),
        .crossover_pairs(crossover_pairs), .irq(irq));

    // Free-running clock at 250 MHz.
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard: the whole run needs well under two thousand cycles.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input phy_status_pkg::phy_events_t ev);
        @(posedge pclk);
        events <= ev;
        @(posedge pclk);
        events <= '0;
        repeat (2) @(posedge pclk);
    endtask

    // Reset values of the summary and the control registers.
    task automatic t_reset();
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW);
        chk({31'h0, rd_err}, 32'h0);
        apb(0, `IDX_PCS_CONFIG, 0); chk(rd_data, 32'h0000_0100);
        apb(0, `IDX_PHY_CONTROL, 0); chk(rd_data, 32'h0000_8000);
    endtask

    // Writes to the read-only summary are ignored without error.
    task automatic t_reserved();
        apb(1, `IDX_SUMMARY, 32'hffff_ffff); chk({31'h0, rd_err}, 0);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW);
    endtask

    // Latch-high flags survive summary reads and clear on source reads.
    task automatic t_latch_high();
        pulse(5'h18);
        pulse(5'h07);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h3940);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h3940);
        apb(0, `IDX_RX_ERROR, 0);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h1940);
        apb(0, `IDX_FALSE_CARRIER, 0);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h1140);
        apb(0, `IDX_TENBASE_STATUS, 0);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h0140);
        apb(0, `IDX_AUTONEG_EXPAN, 0);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h0040);
        apb(0, `IDX_BASIC_STATUS, 0);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW);
    endtask

    // Latch-low detect and lock bits, qualified and raw detect.
    task automatic t_latch_low();
        levels <= 3'b110;
        apb(0, `IDX_SUMMARY, 0);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h0600);
        @(posedge pclk);
        levels <= 3'b100;
        @(posedge pclk);
        levels <= 3'b110;
        repeat (3) @(posedge pclk);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h0600);
        apb(1, `IDX_PCS_CONFIG, 0);
        levels <= 3'b100;
        apb(0, `IDX_SUMMARY, 0);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h0400);
        apb(1, `IDX_PCS_CONFIG, 32'h0000_0100);
        apb(0, `IDX_SUMMARY, 0);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW);
        levels <= 3'b000;
        apb(0, `IDX_SUMMARY, 0);
    endtask

    // Crossover bit is one when forced, else follows the algorithm in auto mode.
    task automatic t_crossover();
        levels <= 3'b001;
        repeat (3) @(posedge pclk);
        chk({31'h0, crossover_pairs}, 1);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h4000);
        levels <= 3'b000;
        repeat (3) @(posedge pclk);
        chk({31'h0, crossover_pairs}, 0);
        apb(1, `IDX_PHY_CONTROL, 32'h0000_4000);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW | 32'h4000);
        apb(1, `IDX_PHY_CONTROL, 32'h0);
        apb(0, `IDX_SUMMARY, 0); chk(rd_data, LOW);
        apb(1, `IDX_PHY_CONTROL, 32'h0000_8000);
    endtask

    // Interrupt raised, masked and cleared; unmapped index answers error.
    task automatic t_irq();
        apb(1, `IDX_IRQ_STATUS, 32'h7f);
        apb(0, `IDX_IRQ_STATUS, 0); chk(rd_data, 0);
        apb(1, `IDX_IRQ_MASK, 32'h01);
        pulse(5'h10);
        chk({31'h0, irq}, 1);
        apb(0, `IDX_IRQ_STATUS, 0); chk(rd_data, 32'h0000_0001);
        apb(1, `IDX_IRQ_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 0);
        apb(1, `IDX_IRQ_MASK, 32'h01);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 1);
        apb(1, `IDX_IRQ_STATUS, 32'h01);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 0);
        apb(0, `IDX_RX_ERROR, 0);
        apb(0, 8'hff, 0); chk({31'h0, rd_err}, 1);
    endtask

    // Main sequence: reset for two cycles, then every scenario in turn.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        events = '0;
        levels = '0;
        lower_status = 6'h2a;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_reserved();
        t_latch_high();
        t_latch_low();
        t_crossover();
        t_irq();
        report_and_stop();
    end
endmodule // phy_status_summary_upper_tb
